// File: ptt_top.sv
// test traffic controller for the udp offload core: tx pattern, rx check, core setup
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module ptt_top #(
  parameter int BLINK_CYCLES = ptt_pkg::BLINK_CYCLES,
  parameter logic [31:0] TOTAL_LEN = ptt_pkg::TOTAL_LEN_BYTES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  // user pins
  input wire logic init_button,
  input wire logic send_button,
  input wire logic packet_size_switch,
  output logic rx_mismatch_led,
  // offload core registers
  output logic [3:0] core_reg_addr,
  output logic [31:0] core_reg_wdata,
  output logic core_reg_wr,
  input wire logic core_busy,
  // offload core tx fifo
  output logic [31:0] core_tx_data,
  output logic core_tx_wr,
  input wire logic core_tx_full,
  // offload core rx fifo
  input wire logic [31:0] core_rx_data,
  input wire logic core_rx_empty,
  output logic core_rx_rd
);
  import ptt_pkg::*;

  ptt_state_t state_r;
  logic [2:0] init_sync_r, send_sync_r;
  logic [1:0] jumbo_sync_r;
  logic init_evt, send_evt, busy_d_r, busy_fall;
  logic [2:0] param_idx_r;
  logic verify_en_r, init_req_r, send_req_r;
  logic [PTT_INT_W-1:0] int_stat_r, int_mask_r, int_set;
  logic tx_active_r, tx_start, tx_last;
  logic [31:0] tx_patt_r;
  logic [31:0] pkt_words_r, word_cnt_r;
  logic [32:0] byte_cnt_r;
  logic rd_d_r, rx_mismatch;
  logic [31:0] rx_expect_r, rx_err_cnt_r;
  logic [31:0] blink_cnt_r;
  logic aw_held_r, w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; third stage only feeds the edge detector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_sync_r <= 3'h0;
      send_sync_r <= 3'h0;
      jumbo_sync_r <= 2'h0;
      busy_d_r <= 1'b0;
    end else begin
      init_sync_r <= {init_sync_r[1:0], init_button};
      send_sync_r <= {send_sync_r[1:0], send_button};
      jumbo_sync_r <= {jumbo_sync_r[0], packet_size_switch};
      busy_d_r <= core_busy;
    end
  end
  assign init_evt = (init_sync_r[1] & ~init_sync_r[2]) | init_req_r;
  assign send_evt = (send_sync_r[1] & ~send_sync_r[2]) | send_req_r;
  assign busy_fall = busy_d_r & ~core_busy;

  ////////////////////////////////////////////////////////////////////////
  // control state machine and core register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= wait_init_btn_state;
      param_idx_r <= 3'h0;
      core_reg_wr <= 1'b0;
      core_reg_addr <= 4'h0;
      core_reg_wdata <= 32'h0000_0000;
    end else begin
      core_reg_wr <= 1'b0;
      unique case (state_r)
        wait_init_btn_state: begin
          if (init_evt) begin
            state_r <= set_param_state;
          end
        end
        set_param_state: begin
          core_reg_wr <= 1'b1;
          core_reg_addr <= PARAM_ADDR[param_idx_r];
          core_reg_wdata <= PARAM_VAL[param_idx_r];
          param_idx_r <= param_idx_r + 3'h1;
          if (param_idx_r == PARAM_LAST) begin
            param_idx_r <= 3'h0;
            state_r <= release_core_reset_state;
          end
        end
        release_core_reset_state: begin
          core_reg_wr <= 1'b1;
          core_reg_addr <= CORE_RST_REG;
          core_reg_wdata <= CORE_RST_RELEASE;
          state_r <= wait_init_done_state;
        end
        wait_init_done_state: begin
          if (busy_fall) begin
            state_r <= idle_wait_cmd_state;
          end
        end
        idle_wait_cmd_state: begin
          if (send_evt) begin
            state_r <= write_total_len_state;
          end
        end
        write_total_len_state: begin
          core_reg_wr <= 1'b1;
          core_reg_addr <= TOTAL_LEN_REG;
          core_reg_wdata <= TOTAL_LEN;
          state_r <= write_pkt_len_state;
        end
        write_pkt_len_state: begin
          core_reg_wr <= 1'b1;
          core_reg_addr <= PKT_LEN_REG;
          core_reg_wdata <= ptt_pkt_bytes(jumbo_sync_r[1]);
          state_r <= write_command_state;
        end
        write_command_state: begin
          core_reg_wr <= 1'b1;
          core_reg_addr <= CORE_CMD_REG;
          core_reg_wdata <= CORE_CMD_SEND;
          state_r <= wait_transfer_done_state;
        end
        wait_transfer_done_state: begin
          // a falling busy edge marks the end; rising edge may lag the command
          if (busy_fall) begin
            state_r <= idle_wait_cmd_state;
          end
        end
        default: state_r <= wait_init_btn_state;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // tx pattern generator
  assign tx_start = (state_r == write_command_state);
  assign tx_last = (byte_cnt_r + WORD_BYTES + WORD_BYTES) > {1'b0, TOTAL_LEN};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_active_r <= 1'b0;
      tx_patt_r <= 32'h0000_0000;
      word_cnt_r <= 32'h0000_0000;
      byte_cnt_r <= 33'h0_0000_0000;
      pkt_words_r <= 32'h0000_0000;
      core_tx_wr <= 1'b0;
    end else begin
      // every other cycle at most, so a lagging full flag cannot overflow
      core_tx_wr <= tx_active_r & ~core_tx_full & ~core_tx_wr;
      if (tx_start) begin
        tx_active_r <= 1'b1;
        tx_patt_r <= 32'h0000_0000;
        word_cnt_r <= 32'h0000_0000;
        byte_cnt_r <= 33'h0_0000_0000;
        pkt_words_r <= ptt_pkt_bytes(jumbo_sync_r[1]) >> 2;
      end else if (core_tx_wr) begin
        byte_cnt_r <= byte_cnt_r + WORD_BYTES;
        if (word_cnt_r == pkt_words_r - 32'h0000_0001) begin
          word_cnt_r <= 32'h0000_0000;
          tx_patt_r <= tx_patt_r + 32'h0000_0001;
        end else begin
          word_cnt_r <= word_cnt_r + 32'h0000_0001;
        end
        if (tx_last) begin
          tx_active_r <= 1'b0;
        end
      end
    end
  end
  assign core_tx_data = tx_patt_r;

  ////////////////////////////////////////////////////////////////////////
  // rx checker; flags mismatches only after the control verify bit is written, runs beside tx
  assign rx_mismatch = rd_d_r & verify_en_r & (core_rx_data != rx_expect_r);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_rx_rd <= 1'b0;
      rd_d_r <= 1'b0;
      rx_expect_r <= 32'h0000_0000;
      rx_err_cnt_r <= 32'h0000_0000;
    end else begin
      core_rx_rd <= ~core_rx_empty & ~core_rx_rd;
      rd_d_r <= core_rx_rd;
      if (rd_d_r) begin
        // resync on the word seen, so one break counts once
        rx_expect_r <= core_rx_data + 32'h0000_0001;
      end
      if (rx_mismatch) begin
        rx_err_cnt_r <= rx_err_cnt_r + 32'h0000_0001;
      end
    end
  end

  // led blinks while the mismatch flag is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_cnt_r <= 32'h0000_0000;
      rx_mismatch_led <= 1'b0;
    end else if (!int_stat_r[PTT_INT_MISMATCH_BIT]) begin
      blink_cnt_r <= 32'h0000_0000;
      rx_mismatch_led <= 1'b0;
    end else if (blink_cnt_r == 32'(BLINK_CYCLES - 1)) begin
      blink_cnt_r <= 32'h0000_0000;
      rx_mismatch_led <= ~rx_mismatch_led;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel
  assign wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PTT_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held_r & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= ~w_held_r & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r == PTT_CTRL_ADDR || awaddr_r == PTT_INT_STAT_ADDR ||
          awaddr_r == PTT_INT_MASK_ADDR) ? PTT_RESP_OKAY : PTT_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control, mask and sticky status; a set beats a same-cycle clear
  assign int_set = {state_r == wait_transfer_done_state && busy_fall,
    state_r == wait_init_done_state && busy_fall, rx_mismatch};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      verify_en_r <= 1'b0;
      init_req_r <= 1'b0;
      send_req_r <= 1'b0;
      int_mask_r <= '0;
      int_stat_r <= '0;
      irq <= 1'b0;
    end else begin
      init_req_r <= 1'b0;
      send_req_r <= 1'b0;
      if (wr_fire && wstrb_r[0] && awaddr_r == PTT_CTRL_ADDR) begin
        verify_en_r <= wdata_r[PTT_CTRL_VERIFY_BIT];
        init_req_r <= wdata_r[PTT_CTRL_INIT_BIT];
        send_req_r <= wdata_r[PTT_CTRL_SEND_BIT];
      end
      if (wr_fire && wstrb_r[0] && awaddr_r == PTT_INT_MASK_ADDR) begin
        int_mask_r <= wdata_r[PTT_INT_W-1:0];
      end
      if (wr_fire && wstrb_r[0] && awaddr_r == PTT_INT_STAT_ADDR) begin
        int_stat_r <= (int_stat_r & ~wdata_r[PTT_INT_W-1:0]) | int_set;
      end else begin
        int_stat_r <= int_stat_r | int_set;
      end
      irq <= |(int_stat_r & int_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= PTT_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= PTT_RESP_OKAY;
        unique case (s_axi_araddr)
          PTT_CTRL_ADDR: s_axi_rdata <= {31'h0000_0000, verify_en_r};
          PTT_STATUS_ADDR: s_axi_rdata <= {24'h00_0000, core_busy, jumbo_sync_r[1],
            tx_active_r, rx_mismatch_led, state_r};
          PTT_INT_STAT_ADDR: s_axi_rdata <= {29'h0000_0000, int_stat_r};
          PTT_INT_MASK_ADDR: s_axi_rdata <= {29'h0000_0000, int_mask_r};
          PTT_TX_PATT_ADDR: s_axi_rdata <= tx_patt_r;
          PTT_RX_ERR_ADDR: s_axi_rdata <= rx_err_cnt_r;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= PTT_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_patt_in_packet: assert property (
    core_tx_wr && word_cnt_r != pkt_words_r - 32'h0000_0001 |=> $stable(tx_patt_r))
    else $error("pattern changed inside a packet");
  chk_patt_advance: assert property (
    core_tx_wr && !tx_start && word_cnt_r == pkt_words_r - 32'h0000_0001
    |=> tx_patt_r == $past(tx_patt_r) + 32'h0000_0001)
    else $error("pattern did not advance at packet end");
  chk_start_zero: assert property (
    tx_start |=> tx_patt_r == 32'h0000_0000 && tx_active_r)
    else $error("pattern not zero at transfer start");
  chk_stop_total: assert property (
    core_tx_wr |-> byte_cnt_r + WORD_BYTES <= {1'b0, TOTAL_LEN})
    else $error("word written beyond total size");
  chk_rd_nonempty: assert property (
    !core_rx_empty && !core_rx_rd |=> core_rx_rd)
    else $error("rx fifo not popped while non-empty");
  chk_mismatch_flag: assert property (
    rx_mismatch |=> int_stat_r[PTT_INT_MISMATCH_BIT])
    else $error("mismatch not flagged");
  chk_release_zero: assert property (
    state_r == release_core_reset_state |=> core_reg_wr && core_reg_addr == CORE_RST_REG
    && core_reg_wdata == CORE_RST_RELEASE)
    else $error("core reset not released with zero");
  chk_param_first: assert property (
    state_r == wait_init_btn_state && init_evt
    |=> ##1 core_reg_wr && core_reg_addr == SRC_MAC_LOW_REG)
    else $error("init did not start with parameter writes");
  chk_cmd_order: assert property (
    state_r == idle_wait_cmd_state && send_evt |=> ##1 core_reg_addr == TOTAL_LEN_REG
    ##1 core_reg_addr == PKT_LEN_REG ##1 core_reg_addr == CORE_CMD_REG)
    else $error("send writes out of order");
  chk_send_idle_only: assert property (
    state_r inside {wait_init_btn_state, wait_init_done_state} |=>
    state_r != write_total_len_state)
    else $error("send honoured outside idle");
  chk_done_idle: assert property (
    state_r == wait_transfer_done_state && busy_fall |=> state_r == idle_wait_cmd_state)
    else $error("no return to idle after transfer");

  cov_init_done: cover property (state_r == wait_init_done_state && busy_fall);
  cov_tx_packet_end: cover property (core_tx_wr && word_cnt_r == pkt_words_r - 32'h0000_0001);
  cov_rx_mismatch: cover property (rx_mismatch);
  cov_tx_rx_together: cover property (core_tx_wr && core_rx_rd);
endmodule

// File: ptt_pkg.sv
// constants, types and register map of the packet test traffic controller
package ptt_pkg;
  // host register map (byte addresses)
  localparam logic [7:0] PTT_CTRL_ADDR = 8'h00;
  localparam logic [7:0] PTT_STATUS_ADDR = 8'h04;
  localparam logic [7:0] PTT_INT_STAT_ADDR = 8'h08;
  localparam logic [7:0] PTT_INT_MASK_ADDR = 8'h0C;
  localparam logic [7:0] PTT_TX_PATT_ADDR = 8'h10;
  localparam logic [7:0] PTT_RX_ERR_ADDR = 8'h14;
  // control fields
  localparam int PTT_CTRL_VERIFY_BIT = 0;
  localparam int PTT_CTRL_INIT_BIT = 1;
  localparam int PTT_CTRL_SEND_BIT = 2;
  // interrupt fields
  localparam int PTT_INT_MISMATCH_BIT = 0;
  localparam int PTT_INT_INIT_DONE_BIT = 1;
  localparam int PTT_INT_TX_DONE_BIT = 2;
  localparam int PTT_INT_W = 3;
  localparam logic [1:0] PTT_RESP_OKAY = 2'h0;
  localparam logic [1:0] PTT_RESP_SLVERR = 2'h2;
  // offload core register addresses
  localparam logic [3:0] CORE_RST_REG = 4'h0;
  localparam logic [3:0] CORE_CMD_REG = 4'h1;
  localparam logic [3:0] SRC_MAC_LOW_REG = 4'h2;
  localparam logic [3:0] SRC_MAC_HIGH_REG = 4'h3;
  localparam logic [3:0] DST_IP_REG = 4'h4;
  localparam logic [3:0] SRC_IP_REG = 4'h5;
  localparam logic [3:0] DST_PORT_REG = 4'h6;
  localparam logic [3:0] SRC_PORT_REG = 4'h7;
  localparam logic [3:0] TOTAL_LEN_REG = 4'h8;
  localparam logic [3:0] PKT_LEN_REG = 4'h9;
  // parameter values written during initialisation
  localparam int PARAM_NUM = 6;
  localparam logic [2:0] PARAM_LAST = 3'h5;
  localparam logic [3:0] PARAM_ADDR [PARAM_NUM] = '{SRC_MAC_LOW_REG, SRC_MAC_HIGH_REG,
    SRC_IP_REG, SRC_PORT_REG, DST_IP_REG, DST_PORT_REG};
  localparam logic [31:0] PARAM_VAL [PARAM_NUM] = '{32'h0203_0405, 32'h0000_0001,
    32'hC0A8_0B2A, 32'h0000_0FA0, 32'hC0A8_0B19, 32'hEA61_EA60};
  localparam logic [31:0] CORE_RST_RELEASE = 32'h0000_0000;
  localparam logic [31:0] CORE_CMD_SEND = 32'h0000_0000;
  // transfer sizes in bytes
  localparam logic [31:0] PKT_BYTES_NORMAL = 32'h0000_05C0;
  localparam logic [31:0] PKT_BYTES_JUMBO = 32'h0000_230C;
  localparam logic [31:0] TOTAL_LEN_BYTES = 32'hFFFF_FFFF;
  localparam logic [32:0] WORD_BYTES = 33'h0_0000_0004;
  // blink timing
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYCLES = BLINK_MS * CLK_FREQ_KHZ;
  typedef enum logic [3:0] {
    wait_init_btn_state = 4'h0,
    set_param_state = 4'h1,
    release_core_reset_state = 4'h3,
    wait_init_done_state = 4'h2,
    idle_wait_cmd_state = 4'h6,
    write_total_len_state = 4'h7,
    write_pkt_len_state = 4'h5,
    write_command_state = 4'h4,
    wait_transfer_done_state = 4'hC
  } ptt_state_t;
  function automatic logic [31:0] ptt_pkt_bytes(input logic jumbo);
    return jumbo ? PKT_BYTES_JUMBO : PKT_BYTES_NORMAL;
  endfunction
endpackage

// File: ptt_core_model.sv
// behavioural model of the offload core: register port, busy flag, tx and rx fifos
`timescale 1ns/100ps
module ptt_core_model #(
  parameter int TOT_WORDS = 744,
  parameter int INIT_CYCLES = 12
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register port
  input wire logic [3:0] core_reg_addr,
  input wire logic [31:0] core_reg_wdata,
  input wire logic core_reg_wr,
  output logic core_busy,
  // tx fifo
  input wire logic [31:0] core_tx_data,
  input wire logic core_tx_wr,
  output logic core_tx_full,
  // rx fifo
  output logic [31:0] core_rx_data,
  output logic core_rx_empty,
  input wire logic core_rx_rd,
  // remote sender control
  input wire logic rx_go,
  input wire logic [10:0] rx_n,
  input wire logic rx_skip
);
  import ptt_pkg::*;
  logic [35:0] wr_q[$];
  logic [31:0] tx_q[$];
  int busy_cnt;
  int tx_cnt;
  logic [4:0] cyc_r;
  logic [10:0] rx_left_r;
  logic [31:0] rx_val_r;
  logic [31:0] rx_word;
  ////////////////////////////////////////////////////////////////////////////////
  // busy rises on reset release and on command, falls after init or full transfer
  always @(posedge aclk) begin
    if (!aresetn) begin
      core_busy <= 1'b0;
      busy_cnt <= 0;
      tx_cnt <= 0;
      cyc_r <= 5'h00;
    end else begin
      cyc_r <= cyc_r + 5'h01;
      if (core_reg_wr)
        wr_q.push_back({core_reg_addr, core_reg_wdata});
      if (core_tx_wr) begin
        tx_q.push_back(core_tx_data);
        tx_cnt <= tx_cnt + 1;
      end
      if (core_reg_wr && core_reg_addr == CORE_RST_REG) begin
        core_busy <= 1'b1;
        busy_cnt <= INIT_CYCLES;
      end else if (core_reg_wr && core_reg_addr == CORE_CMD_REG) begin
        core_busy <= 1'b1;
        tx_cnt <= 0;
      end else if (busy_cnt > 1) begin
        busy_cnt <= busy_cnt - 1;
      end else if (busy_cnt == 1 || (core_busy && tx_cnt >= TOT_WORDS)) begin
        busy_cnt <= 0;
        core_busy <= 1'b0;
      end
    end
  end
  // periodic back-pressure so the tx side is exercised against a slow fifo
  assign core_tx_full = (cyc_r[4:2] == 3'h7);
  ////////////////////////////////////////////////////////////////////////////////
  // rx fifo with registered data; stale data is inverted so it cannot pass by luck
  assign core_rx_empty = (rx_left_r == 11'h000);
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_left_r <= 11'h000;
      rx_val_r <= 32'h0000_0000;
      core_rx_data <= 32'h0000_0000;
    end else if (rx_go) begin
      rx_left_r <= rx_n;
    end else if (core_rx_rd && rx_left_r != 11'h000) begin
      rx_word = (rx_skip && rx_val_r[2:0] == 3'h5) ? rx_val_r + 32'h1 : rx_val_r;
      core_rx_data <= rx_word;
      rx_val_r <= rx_word + 32'h1;
      rx_left_r <= rx_left_r - 11'h001;
    end else begin
      core_rx_data <= ~core_rx_data;
    end
  end
endmodule

// File: test_packet_test_traffic_controller.sv
// testbench of the packet test traffic controller
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("BAD %0t mismatch got %h exp %h", $time, got, exp); end end
module test_packet_test_traffic_controller;
  import ptt_pkg::*;
  localparam logic [31:0] TOT = 32'h0000_0BA0;
  localparam int TOT_W = 744;
  // one full remote datagram of 8096 bytes, never fragmented
  localparam logic [10:0] DGRAM_W = 11'(8096 / 4);
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, core_reg_wdata, core_tx_data, core_rx_data;
  logic [3:0] s_axi_wstrb, core_reg_addr;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic irq, init_button, send_button, packet_size_switch, rx_mismatch_led, core_reg_wr;
  logic core_busy, core_tx_wr, core_tx_full, core_rx_empty, core_rx_rd, rx_go, rx_skip;
  logic [10:0] rx_n;
  int error_cnt, checks, bad, n;
  // source mac, ip, port, destination ip, ports, then core reset release
  logic [35:0] init_seq [7] = '{{SRC_MAC_LOW_REG, 8'h02, 8'h03, 8'h04, 8'h05},
    {SRC_MAC_HIGH_REG, 16'h0000, 8'h00, 8'h01}, {SRC_IP_REG, 8'd192, 8'd168, 8'd11, 8'd42},
    {SRC_PORT_REG, 32'd4000}, {DST_IP_REG, 8'd192, 8'd168, 8'd11, 8'd25},
    {DST_PORT_REG, 16'd60001, 16'd60000}, {CORE_RST_REG, 32'h0000_0000}};
  ptt_top #(.BLINK_CYCLES(4), .TOTAL_LEN(TOT)) uut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq,
    .init_button, .send_button, .packet_size_switch, .rx_mismatch_led, .core_reg_addr,
    .core_reg_wdata, .core_reg_wr, .core_busy, .core_tx_data, .core_tx_wr, .core_tx_full,
    .core_rx_data, .core_rx_empty, .core_rx_rd);
  ptt_core_model #(.TOT_WORDS(TOT_W), .INIT_CYCLES(12)) core (.aclk, .aresetn,
    .core_reg_addr, .core_reg_wdata, .core_reg_wr, .core_busy, .core_tx_data, .core_tx_wr,
    .core_tx_full, .core_rx_data, .core_rx_empty, .core_rx_rd, .rx_go, .rx_n, .rx_skip);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task finish_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one clock with a bound, so no wait can hang the run
  task tick(inout int cnt, input int lim);
    @(posedge aclk);
    cnt++;
    if (cnt > lim) begin
      error_cnt++;
      $display("BAD %0t wait timed out", $time);
      finish_test();
    end
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      tick(n, 100);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1)
      tick(n, 100);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
    @(posedge aclk);
  endtask
  task axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do tick(n, 100); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1)
      tick(n, 100);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, exp)
    `CHK(s_axi_rresp, er)
    @(posedge aclk);
  endtask
  // buttons are held well past the two-stage synchroniser
  task press(input bit snd);
    if (snd) send_button <= 1'b1; else init_button <= 1'b1;
    repeat (6) @(posedge aclk);
    send_button <= 1'b0;
    init_button <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask
  task rx_burst(input logic [10:0] cnt, input logic skip);
    rx_n <= cnt;
    rx_skip <= skip;
    rx_go <= 1'b1;
    @(posedge aclk);
    rx_go <= 1'b0;
    n = 0;
    do tick(n, 5000); while (core_rx_empty !== 1'b1);
    repeat (4) @(posedge aclk);
  endtask
  task wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1)
      tick(n, lim);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {init_button, send_button, packet_size_switch, rx_go, rx_skip} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_n} = '0;
    s_axi_wstrb = 4'hF;
    error_cnt = 0;
    checks = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(PTT_STATUS_ADDR, 32'h0000_0000, PTT_RESP_OKAY);
    axi_rd(8'h18, 32'h0000_0000, PTT_RESP_SLVERR);
    axi_wr(PTT_STATUS_ADDR, 32'h0000_0001, PTT_RESP_SLVERR);
    axi_wr(PTT_INT_MASK_ADDR, 32'h0000_0007, PTT_RESP_OKAY);
    press(1'b1);
    `CHK(core.wr_q.size(), 0)
    press(1'b0);
    wait_irq(300);
    for (int i = 0; i < 7; i++)
      `CHK(core.wr_q[i], init_seq[i])
    axi_rd(PTT_INT_STAT_ADDR, 32'h0000_0002, PTT_RESP_OKAY);
    axi_wr(PTT_INT_STAT_ADDR, 32'h0000_0002, PTT_RESP_OKAY);
    `CHK(irq, 1'b0)
    axi_rd(PTT_STATUS_ADDR, 32'h0000_0006, PTT_RESP_OKAY);
    press(1'b0);
    `CHK(core.wr_q.size(), 7)
    axi_wr(PTT_CTRL_ADDR, 32'h0000_0001, PTT_RESP_OKAY);
    rx_burst(11'h004, 1'b0);
    axi_rd(PTT_RX_ERR_ADDR, 32'h0000_0000, PTT_RESP_OKAY);
    // mismatch masked so only transfer completion raises the interrupt
    axi_wr(PTT_INT_MASK_ADDR, 32'h0000_0004, PTT_RESP_OKAY);
    press(1'b1);
    rx_burst(11'h004, 1'b1);
    wait_irq(8000);
    `CHK(core.wr_q[7], {TOTAL_LEN_REG, TOT})
    `CHK(core.wr_q[8], {PKT_LEN_REG, 32'd1472})
    `CHK(core.wr_q[9], {CORE_CMD_REG, CORE_CMD_SEND})
    `CHK(core.tx_q.size(), TOT_W)
    bad = 0;
    foreach (core.tx_q[i])
      if (core.tx_q[i] !== 32'(i / 368)) bad++;
    `CHK(bad, 0)
    axi_rd(PTT_TX_PATT_ADDR, 32'h0000_0002, PTT_RESP_OKAY);
    axi_rd(PTT_RX_ERR_ADDR, 32'h0000_0001, PTT_RESP_OKAY);
    axi_rd(PTT_INT_STAT_ADDR, 32'h0000_0005, PTT_RESP_OKAY);
    n = 0;
    while (rx_mismatch_led !== 1'b1) tick(n, 20);
    while (rx_mismatch_led !== 1'b0) tick(n, 20);
    axi_wr(PTT_INT_STAT_ADDR, 32'h0000_0007, PTT_RESP_OKAY);
    repeat (6) @(posedge aclk);
    `CHK(rx_mismatch_led, 1'b0)
    `CHK(irq, 1'b0)
    axi_wr(PTT_CTRL_ADDR, 32'h0000_0000, PTT_RESP_OKAY);
    rx_burst(DGRAM_W, 1'b1);
    axi_rd(PTT_RX_ERR_ADDR, 32'h0000_0001, PTT_RESP_OKAY);
    axi_rd(PTT_INT_STAT_ADDR, 32'h0000_0000, PTT_RESP_OKAY);
    packet_size_switch <= 1'b1;
    core.tx_q.delete();
    repeat (4) @(posedge aclk);
    axi_wr(PTT_CTRL_ADDR, 32'h0000_0004, PTT_RESP_OKAY);
    wait_irq(8000);
    `CHK(core.wr_q[11], {PKT_LEN_REG, 32'd8972})
    `CHK(core.tx_q.size(), TOT_W)
    axi_rd(PTT_STATUS_ADDR, 32'h0000_0046, PTT_RESP_OKAY);
    finish_test();
  end
  initial begin
    n = 0;
    repeat (60000) @(posedge aclk);
    error_cnt++;
    $display("BAD %0t run limit reached", $time);
    finish_test();
  end
endmodule
